// ===== cpd_cfg.svh
// Functional notes
// - Never claim on the target side a cycle our own master started.
// - Ignore cacheable, noncacheable memory and memory controller registers.
// - Top 01, bits 31:28 = 1010 claims own control/status registers.
// - Top 01, 1011: read gives interrupt acknowledge, write gives special cycle.
// - Top 01, 110X decodes as sparse I/O space, 16 MB reach; no I/O address is formed, pci_addr_q keeps its last value.
// - Top 01, 111X decodes as configuration space, configuration cycles.
// - Top 11 is 4 GB dense memory space, prefetch allowed.
// - Top 10 is sparse memory; read gives memory read, write memory write.
// - Sparse memory moves at most one quadword, never prefetches.
// - Sparse memory length, byte enables, low address from bits 7:3.
// - Address bits 31:8 go to AD 26:3 in the address phase.
// - AD 31:27 zero when bits 31:29 zero, else programmable extension.
// - Byte length gives enables 1110,1101,1011,0111 by bits 6:5.
// - Word length gives 1100,1001,0011; offset 11 illegal.
// - Tribyte gives 1000,0001; longword and quadword give 0000.
// - PCI address bit 2 from bit 7, bits 1:0 zero; quadword 000.
// - Illegal bits 6:3 still accepted, result undefined.
`ifndef CPD_CFG_SVH
`define CPD_CFG_SVH
`define CPD_TOP_CACHE 2'h0
`define CPD_TOP_IO 2'h1
`define CPD_TOP_SPARSE 2'h2
`define CPD_TOP_DENSE 2'h3
`define CPD_SUB_OWN_CSR 4'ha
`define CPD_SUB_IACK 4'hb
`define CPD_SUB_SPIO 3'h6
`define CPD_SUB_CONFIG 3'h7
`define CPD_LEN_BYTE 2'h0
`define CPD_LEN_WORD 2'h1
`define CPD_LEN_TRI 2'h2
`define CPD_LEN_LONG 2'h3
`define CPD_OFS_QUAD 2'h3
`define CPD_BE_NONE 4'hf
`define CPD_BE_ALL 4'h0
`define CPD_BE_B0 4'he
`define CPD_BE_B1 4'hd
`define CPD_BE_B2 4'hb
`define CPD_BE_B3 4'h7
`define CPD_BE_W0 4'hc
`define CPD_BE_W1 4'h9
`define CPD_BE_W2 4'h3
`define CPD_BE_T0 4'h8
`define CPD_BE_T1 4'h1
`define CPD_FIXED_EXT 5'h00
`define CPD_ZERO_HI 3'h0
`define CPD_LOW_ZERO 2'h0
`define CPD_CMD_IACK 4'h0
`define CPD_CMD_SPECIAL 4'h1
`define CPD_CMD_IO_RD 4'h2
`define CPD_CMD_IO_WR 4'h3
`define CPD_CMD_MEM_RD 4'h6
`define CPD_CMD_MEM_WR 4'h7
`define CPD_CMD_CFG_RD 4'ha
`define CPD_CMD_CFG_WR 4'hb
`define CPD_CMD_MEM_RD_LINE 4'he
`endif

// ===== cpd_pkg.sv
package cpd_pkg;
  typedef enum logic [2:0] {
    CPD_SP_NONE,
    CPD_SP_OWN_CSR,
    CPD_SP_IACK_SPECIAL,
    CPD_SP_SPARSE_IO,
    CPD_SP_CONFIG,
    CPD_SP_SPARSE_MEM,
    CPD_SP_DENSE_MEM
  } cpd_space_e;
endpackage

// ===== cpd_sparse_be.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpd_cfg.svh"
module cpd_sparse_be
  import cpd_pkg::*;
(
  input wire logic [7:3] addr_low,
  output logic [3:0] byte_en_n,
  output logic [2:0] pci_low,
  output logic is_quad,
  output logic illegal
);
  logic [1:0] ofs;
  logic [1:0] len;
  assign ofs = addr_low[6:5];
  assign len = addr_low[4:3];
  always_comb begin
    byte_en_n = `CPD_BE_NONE;
    illegal = 1'b0;
    is_quad = 1'b0;
    unique case (len)
      `CPD_LEN_BYTE: begin
        unique case (ofs)
          2'h0: byte_en_n = `CPD_BE_B0;
          2'h1: byte_en_n = `CPD_BE_B1;
          2'h2: byte_en_n = `CPD_BE_B2;
          2'h3: byte_en_n = `CPD_BE_B3;
        endcase
      end
      `CPD_LEN_WORD: begin
        unique case (ofs)
          2'h0: byte_en_n = `CPD_BE_W0;
          2'h1: byte_en_n = `CPD_BE_W1;
          2'h2: byte_en_n = `CPD_BE_W2;
          2'h3: illegal = 1'b1;
        endcase
      end
      `CPD_LEN_TRI: begin
        unique case (ofs)
          2'h0: byte_en_n = `CPD_BE_T0;
          2'h1: byte_en_n = `CPD_BE_T1;
          2'h2, 2'h3: illegal = 1'b1;
        endcase
      end
      `CPD_LEN_LONG: begin
        unique case (ofs)
          2'h0: byte_en_n = `CPD_BE_ALL;
          `CPD_OFS_QUAD: begin
            byte_en_n = `CPD_BE_ALL;
            is_quad = 1'b1;
          end
          2'h1, 2'h2: illegal = 1'b1;
        endcase
      end
    endcase
    // Bit 2 from bit 7, bits 1:0 zero; quadword all zero
    pci_low = is_quad ? 3'h0 : {addr_low[7], `CPD_LOW_ZERO};
  end
endmodule
`default_nettype wire

// ===== cpd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpd_cfg.svh"
module cpd_decoder
  import cpd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic [33:0] system_bus_address,
  input wire logic [4:0] programmable_memory_high_extension,
  input wire logic pci_target_addr_valid,
  input wire logic pci_target_in_window,
  output logic claim_q,
  output logic [2:0] space_q,
  output logic pci_start_q,
  output logic [3:0] pci_cmd_q,
  output logic [31:0] pci_addr_q,
  output logic [3:0] pci_byte_en_n_q,
  output logic pci_single_q,
  output logic pci_prefetch_ok_q,
  output logic sparse_illegal_q,
  output logic target_claim_q
);
  cpd_space_e space_d;
  logic [3:0] be_n;
  logic [2:0] low;
  logic quad;
  logic illegal;
  logic own_master_q;

  function automatic cpd_space_e decode_space(input logic [5:0] hi);
    cpd_space_e s;
    s = CPD_SP_NONE;
    unique case (hi[5:4])
      `CPD_TOP_CACHE: s = CPD_SP_NONE;
      `CPD_TOP_SPARSE: s = CPD_SP_SPARSE_MEM;
      `CPD_TOP_DENSE: s = CPD_SP_DENSE_MEM;
      `CPD_TOP_IO: begin
        if (hi[3:0] == `CPD_SUB_OWN_CSR)
          s = CPD_SP_OWN_CSR;
        else if (hi[3:0] == `CPD_SUB_IACK)
          s = CPD_SP_IACK_SPECIAL;
        else if (hi[3:1] == `CPD_SUB_SPIO)
          s = CPD_SP_SPARSE_IO;
        else if (hi[3:1] == `CPD_SUB_CONFIG)
          s = CPD_SP_CONFIG;
        else
          s = CPD_SP_NONE;
      end
    endcase
    return s;
  endfunction

  // One space per cycle from bits 33:28
  assign space_d = decode_space(system_bus_address[33:28]);

  cpd_sparse_be u_be (
    .addr_low(system_bus_address[7:3]),
    .byte_en_n(be_n),
    .pci_low(low),
    .is_quad(quad),
    .illegal(illegal)
  );

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      claim_q <= 1'b0;
      space_q <= 3'h0;
    end else begin
      claim_q <= cyc_valid && (space_d != CPD_SP_NONE);
      space_q <= cyc_valid ? 3'(space_d) : 3'h0;
    end
  end

  // PCI master cycle launch for spaces that leave the bridge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pci_start_q <= 1'b0;
      pci_cmd_q <= `CPD_CMD_MEM_RD;
      pci_single_q <= 1'b0;
      pci_prefetch_ok_q <= 1'b0;
      own_master_q <= 1'b0;
    end else begin
      pci_start_q <= 1'b0;
      pci_single_q <= 1'b0;
      pci_prefetch_ok_q <= 1'b0;
      // Own cycle spans the start cycle and the one after it
      own_master_q <= pci_start_q;
      if (cyc_valid) begin
        unique case (space_d)
          CPD_SP_IACK_SPECIAL: begin
            pci_start_q <= 1'b1;
            pci_cmd_q <= cyc_write ? `CPD_CMD_SPECIAL : `CPD_CMD_IACK;
          end
          CPD_SP_SPARSE_IO: begin
            pci_start_q <= 1'b1;
            pci_cmd_q <= cyc_write ? `CPD_CMD_IO_WR : `CPD_CMD_IO_RD;
          end
          CPD_SP_CONFIG: begin
            pci_start_q <= 1'b1;
            pci_cmd_q <= cyc_write ? `CPD_CMD_CFG_WR : `CPD_CMD_CFG_RD;
          end
          CPD_SP_SPARSE_MEM: begin
            pci_start_q <= 1'b1;
            pci_single_q <= 1'b1;
            pci_cmd_q <= cyc_write ? `CPD_CMD_MEM_WR : `CPD_CMD_MEM_RD;
          end
          CPD_SP_DENSE_MEM: begin
            pci_start_q <= 1'b1;
            pci_prefetch_ok_q <= ~cyc_write;
            pci_cmd_q <= cyc_write ? `CPD_CMD_MEM_WR : `CPD_CMD_MEM_RD_LINE;
          end
          CPD_SP_NONE, CPD_SP_OWN_CSR: ;
        endcase
      end
    end
  end

  // Sparse and dense memory address phase and byte enables
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pci_addr_q <= 32'h0;
      pci_byte_en_n_q <= `CPD_BE_NONE;
      sparse_illegal_q <= 1'b0;
    end else if (cyc_valid && space_d == CPD_SP_SPARSE_MEM) begin
      pci_addr_q[26:3] <= system_bus_address[31:8];
      pci_addr_q[31:27] <= (system_bus_address[31:29] == `CPD_ZERO_HI) ?
        `CPD_FIXED_EXT : programmable_memory_high_extension;
      pci_addr_q[2:0] <= low;
      pci_byte_en_n_q <= be_n;
      sparse_illegal_q <= illegal;
    end else if (cyc_valid && space_d == CPD_SP_DENSE_MEM) begin
      pci_addr_q <= system_bus_address[31:0];
      pci_byte_en_n_q <= `CPD_BE_ALL;
      sparse_illegal_q <= 1'b0;
    end
  end

  // Target side never claims our own master's address
  always_ff @(posedge clk_sys) begin
    if (!resetn)
      target_claim_q <= 1'b0;
    else
      target_claim_q <= pci_target_addr_valid && pci_target_in_window &&
        !own_master_q && !pci_start_q;
  end
endmodule
`default_nettype wire

// ===== cpd_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cpd_decoder_asserts
  import cpd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic [33:0] system_bus_address,
  input wire logic [4:0] programmable_memory_high_extension,
  input wire logic pci_target_addr_valid,
  input wire logic pci_target_in_window,
  input wire logic claim_q,
  input wire logic [2:0] space_q,
  input wire logic pci_start_q,
  input wire logic [3:0] pci_cmd_q,
  input wire logic [31:0] pci_addr_q,
  input wire logic [3:0] pci_byte_en_n_q,
  input wire logic pci_single_q,
  input wire logic pci_prefetch_ok_q,
  input wire logic target_claim_q
);
  logic [33:0] a_q;
  logic [4:0] ext_q;
  logic w_q;
  wire logic [5:0] top = system_bus_address[33:28];
  wire logic sp = cyc_valid && top[5:4] == 2'h2;
  always_ff @(posedge clk_sys) begin
    a_q <= system_bus_address;
    ext_q <= programmable_memory_high_extension;
    w_q <= cyc_write;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_IGNORE: assert property (cyc_valid && (top[5:4] == 2'h0 ||
    top[5:3] == 3'h2 || top[5:1] == 5'h0c) |=> !claim_q && !pci_start_q)
    else $error("ignored space claimed");
  AST_OWN_CSR: assert property (cyc_valid && top == 6'h1a |=> claim_q &&
    !pci_start_q && space_q == CPD_SP_OWN_CSR) else $error("csr decode");
  AST_IACK: assert property (cyc_valid && top == 6'h1b |=>
    pci_start_q && pci_cmd_q == {3'h0, w_q}) else $error("iack command");
  AST_IO_CFG: assert property (cyc_valid && top[5:2] == 4'h7 |=>
    pci_start_q && pci_cmd_q == {a_q[29], 2'h1, w_q}) else $error("io cfg");
  AST_DENSE: assert property (cyc_valid && top[5:4] == 2'h3 |=>
    space_q == CPD_SP_DENSE_MEM && pci_prefetch_ok_q == !w_q)
    else $error("dense decode");
  AST_SPARSE: assert property (sp |=>
    pci_start_q && pci_single_q &&
    !pci_prefetch_ok_q && pci_cmd_q == {3'h3, w_q}) else $error("sparse");
  AST_SP_ADDR: assert property (sp |=>
    pci_addr_q[26:3] == a_q[31:8] &&
    pci_addr_q[31:27] == (a_q[31:29] == 3'h0 ? 5'h00 : ext_q))
    else $error("sparse address");
  AST_SP_QUAD: assert property (sp &&
    system_bus_address[6:3] == 4'hf |=>
    pci_addr_q[2:0] == 3'h0 && pci_byte_en_n_q == 4'h0) else $error("quad");
  AST_SP_BYTE: assert property (sp &&
    system_bus_address[4:3] == 2'h0 |=>
    pci_byte_en_n_q == ~(4'h1 << a_q[6:5]) &&
    pci_addr_q[2:0] == {a_q[7], 2'h0})
    else $error("byte lane");
  AST_TGT_MUTE: assert property (pci_target_addr_valid && (pci_start_q ||
    $past(pci_start_q)) |=> !target_claim_q) else $error("loopback claim");
  AST_TGT_HIT: assert property (pci_target_addr_valid &&
    pci_target_in_window && !pci_start_q && !$past(pci_start_q) |=>
    target_claim_q) else $error("target missed");
  AST_ONE_SPACE: assert property (claim_q == (space_q != 3'h0))
    else $error("claim without space");
  cover property (pci_start_q && pci_single_q);
  cover property (claim_q && !pci_start_q);
  cover property (target_claim_q);
endmodule
`default_nettype wire

// ===== cpd_partner.sv
`timescale 1ns/1ps
`default_nettype none
module cpd_partner (
  input wire logic clk_sys,
  output logic cyc_valid,
  output logic cyc_write,
  output logic [33:0] system_bus_address,
  output logic pci_target_addr_valid,
  output logic pci_target_in_window
);
  initial begin
    cyc_valid = 1'b0;
    cyc_write = 1'b0;
    system_bus_address = 34'h0;
    pci_target_addr_valid = 1'b0;
    pci_target_in_window = 1'b0;
  end
  // Data accesses only; sparse space for byte lanes
  task automatic req(input logic w, input logic [33:0] a);
    @(posedge clk_sys);
    cyc_valid <= 1'b1;
    cyc_write <= w;
    system_bus_address <= a;
    @(posedge clk_sys);
    cyc_valid <= 1'b0;
    cyc_write <= ~w;
    system_bus_address <= ~a;
    #1;
  endtask
  task automatic tgt(input logic win);
    @(posedge clk_sys);
    pci_target_addr_valid <= 1'b1;
    pci_target_in_window <= win;
    @(posedge clk_sys);
    pci_target_addr_valid <= 1'b0;
    pci_target_in_window <= ~win;
    #1;
  endtask
endmodule
`default_nettype wire

// ===== cpd_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cpd_decoder_tb_top
  import cpd_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [33:0] a;
    cpd_space_e sp;
    logic [3:0] cmd;
  } cpd_row_s;
  localparam logic [63:0] be_tab = 64'h0ff7ff3bf19d08ce;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] programmable_memory_high_extension = 5'h15;
  wire logic cyc_valid, cyc_write, pci_target_addr_valid, pci_target_in_window;
  wire logic [33:0] system_bus_address;
  logic claim_q, pci_start_q, pci_single_q, pci_prefetch_ok_q;
  logic sparse_illegal_q, target_claim_q;
  logic [2:0] space_q;
  logic [3:0] pci_cmd_q, pci_byte_en_n_q;
  logic [31:0] pci_addr_q;
  int err_total = 0;
  int compares = 0;
  cpd_row_s rows [11] = '{
    '{1'b0, 34'h000000000, CPD_SP_NONE, 4'h0},
    '{1'b0, 34'h170000000, CPD_SP_NONE, 4'h0},
    '{1'b1, 34'h190000000, CPD_SP_NONE, 4'h0},
    '{1'b0, 34'h1a0000040, CPD_SP_OWN_CSR, 4'h0},
    '{1'b0, 34'h1b0000000, CPD_SP_IACK_SPECIAL, 4'h0},
    '{1'b1, 34'h1b0000000, CPD_SP_IACK_SPECIAL, 4'h1},
    '{1'b0, 34'h1d0000000, CPD_SP_SPARSE_IO, 4'h2},
    '{1'b1, 34'h1c0000000, CPD_SP_SPARSE_IO, 4'h3},
    '{1'b0, 34'h1f0000000, CPD_SP_CONFIG, 4'ha},
    '{1'b1, 34'h1e0000000, CPD_SP_CONFIG, 4'hb},
    '{1'b0, 34'h312345678, CPD_SP_DENSE_MEM, 4'he}};
  always #12.5 clk_sys = ~clk_sys;
  cpd_partner cpd_partner_i (.*);
  cpd_decoder cpd_decoder_i (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20us;
    err_total++;
    finish_test;
  end
  initial begin
    logic [4:0] k;
    logic [23:0] hi;
    logic [3:0] eb;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    check(space_q, 3'h0);
    check(pci_byte_en_n_q, 4'hf);
    foreach (rows[i]) begin
      cpd_partner_i.req(rows[i].w, rows[i].a);
      check(claim_q, rows[i].sp != CPD_SP_NONE);
      check(space_q, rows[i].sp);
      check(pci_start_q, rows[i].sp > CPD_SP_OWN_CSR);
      check(pci_prefetch_ok_q, rows[i].cmd == 4'he);
      if (rows[i].sp > CPD_SP_OWN_CSR) check(pci_cmd_q, rows[i].cmd);
    end
    for (int j = 0; j < 64; j++) begin
      k = j[4:0];
      hi = j[5] ? 24'ha56789 : 24'h012345;
      eb = be_tab[k[3:0] * 4 +: 4];
      cpd_partner_i.req(j[5], {2'h2, hi, k, 3'h0});
      check(space_q, CPD_SP_SPARSE_MEM);
      check(pci_cmd_q, {3'h3, j[5]});
      check({pci_single_q, pci_prefetch_ok_q}, 2'h2);
      check(pci_byte_en_n_q, eb);
      check(sparse_illegal_q, eb == 4'hf);
      if (eb != 4'hf) check(pci_addr_q,
        {hi[23:21] == 3'h0 ? 5'h00 : programmable_memory_high_extension, hi,
        k[3:0] == 4'hf ? 3'h0 : {k[4], 2'h0}});
    end
    @(posedge clk_sys);
    resetn <= 1'b0;
    @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    check({pci_cmd_q, pci_byte_en_n_q}, 8'h6f);
    cpd_partner_i.tgt(1'b1);
    check(target_claim_q, 1'b1);
    cpd_partner_i.tgt(1'b0);
    check(target_claim_q, 1'b0);
    cpd_partner_i.req(1'b0, 34'h200000100);
    cpd_partner_i.tgt(1'b1);
    check(target_claim_q, 1'b0);
    finish_test;
  end
endmodule
bind cpd_decoder cpd_decoder_asserts cpd_decoder_asserts_i (.*);
`default_nettype wire
